// ==== rtl/ccfp_pkg.sv ====
// package for the cabinet fault panel controller: constants, carriers
// assumes one 10 MHz clock and an AHB-Lite register port
package ccfp_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ          = 10;
    localparam int DEB_TIME_US      = 5000;
    localparam int DEB_CYC          = DEB_TIME_US * CLK_MHZ;
    localparam int RST_PULSE_US     = 2;
    localparam int RST_PULSE_CYC    = RST_PULSE_US * CLK_MHZ;
    localparam int TRAY_N           = 4;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_CMD     = 8'h04;
    localparam logic [7:0] REG_STATUS  = 8'h08;
    localparam logic [7:0] REG_SWITCH  = 8'h0c;
    localparam logic [7:0] REG_MODPWR  = 8'h10;
    localparam logic [7:0] REG_MODTEMP = 8'h14;
    localparam int CTRL_LOW_LSB  = 0;
    localparam int CTRL_HIGH_LSB = 2;
    localparam int CTRL_BULK_BIT = 4;
    localparam int CTRL_ALARM_BIT = 5;
    localparam int CMD_CPU_BIT   = 0;
    localparam int CMD_IO_BIT    = 1;
    localparam logic [5:0] CTRL_RESET = 6'h30;

    typedef enum logic [1:0] {
        CCFP_MARGIN_NOM  = 2'b00,
        CCFP_MARGIN_UP   = 2'b01,
        CCFP_MARGIN_DOWN = 2'b10
    } ccfp_margin_e;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                airflow_bad;
        logic                ctrl_12v_lost;
        logic                ctrl_48v_lost;
        logic                battery_fault;
        logic [TRAY_N-1:0]   tray_supply_fail;
        logic [TRAY_N-1:0]   tray_fan_fail;
        logic                clock_low_bad;
        logic                clock_high_bad;
        logic                low_rail_margin_up;
        logic                low_rail_margin_down;
        logic                high_rail_margin_up;
        logic                high_rail_margin_down;
        logic                module_power_enable_switch;
        logic                bulk_power_enable_switch;
        logic                alarm_enable_switch;
        logic                remote_select;
        logic                battery_switch_on;
        logic                lamp_test_button;
        logic                alarm_ack_button;
        logic                cpu_reset_button;
        logic                io_reset_button;
    } ccfp_pins_s;

    typedef struct packed {
        logic blower_fault_led;
        logic ctrl_12v_fault_led;
        logic ctrl_48v_fault_led;
        logic battery_fault_led;
        logic tray_supply_fault_led;
        logic tray_fan_fault_led;
        logic clock_power_fault_led;
        logic service_state_led;
        logic system_ok_led;
    } ccfp_leds_s;

    typedef struct packed {
        ccfp_margin_e low_rail;
        ccfp_margin_e high_rail;
    } ccfp_margin_s;

    localparam ccfp_leds_s LEDS_RESET = '0;

endpackage : ccfp_pkg

// ==== rtl/ccfp_debounce.sv ====
// two-flop synchroniser and stability filter for a vector of pins
// assumes raw inputs are asynchronous to clk
`timescale 1ns/10ps
`default_nettype none
module ccfp_debounce
    import ccfp_pkg::*;
#(
    parameter int W   = 8,
    parameter int CNT = DEB_CYC
)(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    // pins and filtered levels
    input  wire logic [W-1:0] raw,
    output var  logic [W-1:0] clean
);
    localparam int CW = $clog2(CNT + 1);
    localparam logic [CW-1:0] LAST = CW'(CNT - 1);

    logic [W-1:0] sync1_reg;
    logic [W-1:0] sync2_reg;

    // first flop feeds only the second
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else if (ce)
        begin
            sync1_reg <= raw;
            sync2_reg <= sync1_reg;
        end
    end

    for (genvar i = 0; i < W; i++)
    begin : g_bit
        logic [CW-1:0] cnt_reg;
        // a level must hold the whole window before it is believed
        always_ff @(posedge clk or posedge rst)
        begin
            if (rst)
            begin
                cnt_reg  <= '0;
                clean[i] <= 1'b0;
            end
            else if (ce)
            begin
                if (sync2_reg[i] == clean[i])
                    cnt_reg <= '0;
                else if (cnt_reg == LAST)
                begin
                    cnt_reg  <= '0;
                    clean[i] <= sync2_reg[i];
                end
                else
                    cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

endmodule : ccfp_debounce
`default_nettype wire

// ==== rtl/ccfp_top.sv ====
// cabinet fault panel controller: fault leds, alarm, power enables, resets
// assumes one 10 MHz clock; panel pins asynchronous; AHB-Lite slave for remote
//
// Operation
// - no airflow lights blower led, halts mainframe
// - 12 V loss lights its led only
// - 48 V loss lights its led
// - any battery fault lights battery led
// - any tray supply failure lights one led
// - any tray fan failure lights one led
// - clock rail low lights clock led
// - module power fault latches until toggle
// - redundant supply leds held off
// - warning or critical heat lights temp led
// - low rail selector decodes to margin command
// - high rail selector decodes the same way
// - panel margins honoured only in local mode
// - module enable switch gates every module supply
// - bulk switch gates front-end 48 V output in local mode; CTRL bit 4 gates it in remote
// - alarm switch at inhibit silences alarm in local mode; CTRL bit 5 does it in remote
// - remote commands act only in remote mode
// - cpu reset button pulses clock module reset
// - io reset button resets every node
// - alarm holds until acknowledged, new faults resound
// - service led on for any abnormal setting
// - lamp test lights everything while held
// - ready led needs no critical fault, bulk on
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module ccfp_top
    import ccfp_pkg::*;
#(
    parameter int N_MOD   = 16,
    parameter int DEB_CNT = DEB_CYC
)(
    // clock, reset, enable
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    // AHB-Lite slave
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic                  hreadyout,
    output logic                  hresp,
    output logic [31:0]           hrdata,
    // panel switches and cabinet sensors
    input  wire ccfp_pins_s       pins,
    input  wire logic [N_MOD-1:0] mod_low_bad,
    input  wire logic [N_MOD-1:0] mod_high_bad,
    input  wire logic [N_MOD-1:0] mod_temp_warn,
    input  wire logic [N_MOD-1:0] mod_temp_crit,
    input  wire logic [N_MOD-1:0] mod_local_enable,
    // indicators
    output ccfp_leds_s            leds,
    output logic [N_MOD-1:0]      module_power_fault_led,
    output logic [N_MOD-1:0]      temp_fault_led,
    output logic [N_MOD-1:0]      redundant_fault_led,
    output logic                  alarm_sound,
    // power and reset outputs
    output ccfp_margin_s          margin_cmd,
    output logic [N_MOD-1:0]      module_supply_en,
    output logic                  clock_supply_en,
    output logic                  bulk_power_on,
    output logic                  mainframe_halt,
    output logic                  cpu_reset_irq,
    output logic                  io_reset_out
);
    localparam int MW = 5 * N_MOD;
    localparam int FW = 7 + 2 * N_MOD;
    localparam int RCW = $clog2(RST_PULSE_CYC + 1);

    // ----------------------------------------------------------------
    // input conditioning
    // ----------------------------------------------------------------
    ccfp_pins_s       db;
    ccfp_pins_s       db_q;
    logic [MW-1:0]    mdb;
    logic [N_MOD-1:0] m_low;
    logic [N_MOD-1:0] m_high;
    logic [N_MOD-1:0] m_warn;
    logic [N_MOD-1:0] m_crit;
    logic [N_MOD-1:0] m_en;
    logic [N_MOD-1:0] m_en_q;

    ccfp_debounce #(.W($bits(ccfp_pins_s)), .CNT(DEB_CNT)) u_pin_db (
        .clk   (clk),
        .rst   (rst),
        .ce    (ce),
        .raw   (pins),
        .clean (db)
    );

    ccfp_debounce #(.W(MW), .CNT(DEB_CNT)) u_mod_db (
        .clk   (clk),
        .rst   (rst),
        .ce    (ce),
        .raw   ({mod_low_bad, mod_high_bad, mod_temp_warn, mod_temp_crit, mod_local_enable}),
        .clean (mdb)
    );

    assign {m_low, m_high, m_warn, m_crit, m_en} = mdb;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            db_q   <= '0;
            m_en_q <= '0;
        end
        else if (ce)
        begin
            db_q   <= db;
            m_en_q <= m_en;
        end
    end

    // one action per press: rising edge of the filtered level
    logic ack_press;
    logic cpu_press;
    logic io_press;
    assign ack_press = db.alarm_ack_button & ~db_q.alarm_ack_button;
    assign cpu_press = db.cpu_reset_button & ~db_q.cpu_reset_button;
    assign io_press  = db.io_reset_button & ~db_q.io_reset_button;

    logic remote;
    logic test;
    assign remote = db.remote_select;
    assign test   = db.lamp_test_button;

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    logic [5:0] ctrl_reg;
    logic       dp_write_reg;
    logic [7:0] dp_addr_reg;
    logic       cpu_cmd;
    logic       io_cmd;
    logic       addr_phase;

    assign addr_phase = hsel & htrans[1] & hready;
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;

    function automatic logic [31:0] read_word(input logic [7:0] a);
        logic [31:0] w;
        w = '0;
        unique case (a)
            REG_CTRL:    w = 32'(ctrl_reg);
            REG_STATUS:  w = 32'(leds);
            REG_SWITCH:  w = 32'(db);
            REG_MODPWR:  w = 32'(module_power_fault_led);
            REG_MODTEMP: w = 32'(temp_fault_led);
            default:     w = '0;
        endcase
        return w;
    endfunction : read_word

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            dp_write_reg <= 1'b0;
            dp_addr_reg  <= '0;
            hrdata       <= '0;
        end
        else if (ce)
        begin
            dp_write_reg <= addr_phase & hwrite;
            if (addr_phase)
            begin
                dp_addr_reg <= haddr[7:0];
                hrdata      <= hwrite ? 32'h0000_0000 : read_word(haddr[7:0]);
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ctrl_reg <= CTRL_RESET;
        else if (ce && dp_write_reg && dp_addr_reg == REG_CTRL)
            ctrl_reg <= hwdata[5:0];
    end

    // commands from the register port count only in remote mode
    assign cpu_cmd = ce & dp_write_reg & (dp_addr_reg == REG_CMD) & remote
                   & hwdata[CMD_CPU_BIT];
    assign io_cmd  = ce & dp_write_reg & (dp_addr_reg == REG_CMD) & remote
                   & hwdata[CMD_IO_BIT];

    // ----------------------------------------------------------------
    // control decode
    // ----------------------------------------------------------------
    function automatic ccfp_margin_e decode_margin(input logic up, input logic dn);
        ccfp_margin_e m;
        m = CCFP_MARGIN_NOM;
        if (up && !dn)
            m = CCFP_MARGIN_UP;
        else if (dn && !up)
            m = CCFP_MARGIN_DOWN;
        return m;
    endfunction : decode_margin

    ccfp_margin_s margin_next;
    logic         alarm_en;
    logic         bulk_en;

    always_comb
    begin
        if (remote)
        begin
            margin_next.low_rail  = ccfp_margin_e'(ctrl_reg[CTRL_LOW_LSB +: 2]);
            margin_next.high_rail = ccfp_margin_e'(ctrl_reg[CTRL_HIGH_LSB +: 2]);
            alarm_en = ctrl_reg[CTRL_ALARM_BIT];
            bulk_en  = ctrl_reg[CTRL_BULK_BIT];
        end
        else
        begin
            margin_next.low_rail  = decode_margin(db.low_rail_margin_up,
                                                  db.low_rail_margin_down);
            margin_next.high_rail = decode_margin(db.high_rail_margin_up,
                                                  db.high_rail_margin_down);
            alarm_en = db.alarm_enable_switch;
            bulk_en  = db.bulk_power_enable_switch;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            margin_cmd       <= '{CCFP_MARGIN_NOM, CCFP_MARGIN_NOM};
            module_supply_en <= '0;
            clock_supply_en  <= 1'b0;
            bulk_power_on    <= 1'b0;
            mainframe_halt   <= 1'b1;
        end
        else if (ce)
        begin
            margin_cmd       <= margin_next;
            module_supply_en <= {N_MOD{db.module_power_enable_switch}} & m_en;
            clock_supply_en  <= db.module_power_enable_switch;
            bulk_power_on    <= bulk_en;
            mainframe_halt   <= db.airflow_bad;
        end
    end

    // ----------------------------------------------------------------
    // module power fault latches
    // ----------------------------------------------------------------
    logic [N_MOD-1:0] mod_bad;
    logic [N_MOD-1:0] mod_latch_reg;
    logic [N_MOD-1:0] mod_toggle;
    assign mod_bad    = m_low | m_high;
    assign mod_toggle = m_en & ~m_en_q;

    // set wins; clears on a re-enable once the rail is good
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            mod_latch_reg <= '0;
        else if (ce)
            mod_latch_reg <= mod_bad | (mod_latch_reg & ~mod_toggle);
    end

    // ----------------------------------------------------------------
    // fault indicators
    // ----------------------------------------------------------------
    ccfp_leds_s       leds_next;
    logic             critical;
    logic [FW-1:0]    faults;
    logic [FW-1:0]    faults_q;
    logic [N_MOD-1:0] temp_now;

    assign temp_now = m_warn | m_crit;
    // the 12 V loss is not critical: the 48 V backup keeps control alive
    assign critical = db.airflow_bad | db.clock_low_bad | db.clock_high_bad
                    | (|mod_latch_reg) | (|m_crit);

    always_comb
    begin
        leds_next.blower_fault_led      = db.airflow_bad;
        leds_next.ctrl_12v_fault_led    = db.ctrl_12v_lost;
        leds_next.ctrl_48v_fault_led    = db.ctrl_48v_lost;
        leds_next.battery_fault_led     = db.battery_fault;
        leds_next.tray_supply_fault_led = |db.tray_supply_fail;
        leds_next.tray_fan_fault_led    = |db.tray_fan_fail;
        leds_next.clock_power_fault_led = db.clock_low_bad | db.clock_high_bad;
        leds_next.service_state_led     = (margin_next.low_rail != CCFP_MARGIN_NOM)
                                        | (margin_next.high_rail != CCFP_MARGIN_NOM)
                                        | remote | ~db.battery_switch_on | ~alarm_en
                                        | ~bulk_en | ~db.module_power_enable_switch;
        leds_next.system_ok_led         = ~critical & bulk_en;
        if (test)
            leds_next = '1;
    end

    // raw fault levels, not the lamp-test view, so a test press cannot latch the alarm
    assign faults = {db.airflow_bad, db.ctrl_12v_lost, db.ctrl_48v_lost,
                     db.battery_fault, |db.tray_supply_fail, |db.tray_fan_fail,
                     db.clock_low_bad | db.clock_high_bad, mod_latch_reg, temp_now};

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            leds                   <= LEDS_RESET;
            module_power_fault_led <= '0;
            temp_fault_led         <= '0;
            redundant_fault_led    <= '0;
            faults_q               <= '0;
        end
        else if (ce)
        begin
            leds                   <= leds_next;
            module_power_fault_led <= mod_latch_reg | {N_MOD{test}};
            temp_fault_led         <= temp_now | {N_MOD{test}};
            redundant_fault_led    <= {N_MOD{test}};
            faults_q               <= faults;
        end
    end

    // ----------------------------------------------------------------
    // audible alarm
    // ----------------------------------------------------------------
    logic alarm_reg;
    logic new_fault;
    assign new_fault = |(faults & ~faults_q);

    // a fresh fault in the ack cycle still sounds
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            alarm_reg <= 1'b0;
        else if (ce)
        begin
            if (new_fault && alarm_en)
                alarm_reg <= 1'b1;
            else if (ack_press || !alarm_en)
                alarm_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            alarm_sound <= 1'b0;
        else if (ce)
            alarm_sound <= (alarm_reg & alarm_en) | test;
    end

    // ----------------------------------------------------------------
    // reset pulses
    // ----------------------------------------------------------------
    logic [RCW-1:0] cpu_cnt_reg;
    logic [RCW-1:0] io_cnt_reg;
    localparam logic [RCW-1:0] RST_LEN = RCW'(RST_PULSE_CYC);

    // stretched so the clock module and nodes see a clean pulse
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cpu_cnt_reg <= '0;
            io_cnt_reg  <= '0;
        end
        else if (ce)
        begin
            if (cpu_press || cpu_cmd)
                cpu_cnt_reg <= RST_LEN;
            else if (cpu_cnt_reg != '0)
                cpu_cnt_reg <= cpu_cnt_reg - 1'b1;
            if (io_press || io_cmd)
                io_cnt_reg <= RST_LEN;
            else if (io_cnt_reg != '0)
                io_cnt_reg <= io_cnt_reg - 1'b1;
        end
    end

    assign cpu_reset_irq = (cpu_cnt_reg != '0);
    assign io_reset_out  = (io_cnt_reg != '0);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_press;
        ce && cpu_press;
    endsequence

    sequence s_pulse;
        cpu_reset_irq [*8];
    endsequence

    property p_blower;
        @(posedge clk) disable iff (rst)
        ce && db.airflow_bad |=> mainframe_halt && leds.blower_fault_led;
    endproperty
    a_blower: assert property (p_blower) else $error("airflow loss not shown");

    property p_12v_only;
        @(posedge clk) disable iff (rst)
        ce && db.ctrl_12v_lost && !db.airflow_bad |=> !mainframe_halt;
    endproperty
    a_12v_only: assert property (p_12v_only) else $error("12 V loss halted");

    property p_tray;
        @(posedge clk) disable iff (rst)
        ce && (db.tray_supply_fail != '0) |=> leds.tray_supply_fault_led;
    endproperty
    a_tray: assert property (p_tray) else $error("tray supply fault missed");

    property p_latch;
        @(posedge clk) disable iff (rst)
        ce && mod_bad[0] ##1 ce && !mod_toggle[0] |=> mod_latch_reg[0];
    endproperty
    a_latch: assert property (p_latch) else $error("module fault latch lost");

    property p_redundant;
        @(posedge clk) disable iff (rst)
        ce && !test |=> redundant_fault_led == '0;
    endproperty
    a_redundant: assert property (p_redundant) else $error("redundant led lit");

    property p_remote_margin;
        @(posedge clk) disable iff (rst)
        ce && remote |=> margin_cmd.low_rail == ccfp_margin_e'($past(ctrl_reg[1:0]));
    endproperty
    a_remote_margin: assert property (p_remote_margin) else $error("panel margin in remote");

    property p_alarm_inhibit;
        @(posedge clk) disable iff (rst)
        ce && !alarm_en && !test |=> !alarm_sound;
    endproperty
    a_alarm_inhibit: assert property (p_alarm_inhibit) else $error("alarm while inhibited");

    property p_alarm_hold;
        @(posedge clk) disable iff (rst)
        ce && alarm_reg && alarm_en && !ack_press |=> alarm_reg;
    endproperty
    a_alarm_hold: assert property (p_alarm_hold) else $error("alarm dropped unacked");

    property p_cpu_reset;
        @(posedge clk) disable iff (rst)
        s_press ##1 ce |-> s_pulse;
    endproperty
    a_cpu_reset: assert property (p_cpu_reset) else $error("cpu reset pulse short");

    property p_supply_off;
        @(posedge clk) disable iff (rst)
        ce && !db.module_power_enable_switch |=> module_supply_en == '0 && !clock_supply_en;
    endproperty
    a_supply_off: assert property (p_supply_off) else $error("supply on at inhibit");

endmodule : ccfp_top
`default_nettype wire

// ==== tb/ccfp_panel_model.sv ====
// panel switch, sensor and module rail model
// assumes the bench sets wanted levels; they reach the pins after an edge
`timescale 1ns/10ps
`default_nettype none
module ccfp_panel_model
    import ccfp_pkg::*;
#(
    parameter int N = 4
)(
    // clock
    input  wire logic           clk,
    // wanted and driven levels
    input  wire ccfp_pins_s     want,
    input  wire logic [3*N-1:0] want_mod,
    output ccfp_pins_s          pins,
    output logic [3*N-1:0]      mods
);
    // ------------------------------
    // contacts move only after an edge, never at time of sampling
    // ------------------------------
    always @(posedge clk)
    begin
        pins <= want;
        mods <= want_mod;
    end
endmodule : ccfp_panel_model
`default_nettype wire

// ==== tb/test_ccfp_top.sv ====
// self-checking bench for the fault panel controller
// assumes ccfp_panel_model; short debounce count for speed
`timescale 1ns/10ps
`default_nettype none
module test_ccfp_top
    import ccfp_pkg::*;
;
    // ------------------------------
    // stimulus and checks
    // ------------------------------
    localparam int N = 4;
    logic clk, rst, hsel, hwrite, hreadyout, alarm, halt, cpu_irq, bulk, io_rst;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, q;
    ccfp_pins_s want, pins;
    logic [3*N-1:0] want_mod, mods;
    ccfp_leds_s leds;
    ccfp_margin_s margin;
    logic [N-1:0] pwr_led, temp_led;
    int n_fail, cmp_count;
    ccfp_top #(.N_MOD(N), .DEB_CNT(4)) u_dut (.clk(clk), .rst(rst), .ce(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .pins(pins),
        .mod_low_bad(mods[N-1:0]), .mod_high_bad({N{1'b0}}), .mod_temp_warn(mods[2*N-1:N]),
        .mod_temp_crit({N{1'b0}}), .mod_local_enable(mods[3*N-1:2*N]), .leds(leds),
        .module_power_fault_led(pwr_led), .temp_fault_led(temp_led), .redundant_fault_led(),
        .alarm_sound(alarm), .margin_cmd(margin), .module_supply_en(), .clock_supply_en(),
        .bulk_power_on(bulk), .mainframe_halt(halt), .cpu_reset_irq(cpu_irq),
        .io_reset_out(io_rst));
    ccfp_panel_model #(.N(N)) u_panel (.clk(clk), .want(want), .want_mod(want_mod),
        .pins(pins), .mods(mods));
    task automatic conclude();
        if (n_fail == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            $display("BAD %s exp %h got %h", n, e, g);
            n_fail++;
        end
    endtask : chk
    // master holds each phase until hready is seen high
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic settle();
        repeat (20) @(posedge clk);
        @(negedge clk);
    endtask : settle
    task automatic t_regs();
        bus(1'b0, 32'h0, 32'h0); chk("ctrl", 32'h30, q);
        bus(1'b1, 32'h0, 32'h35); bus(1'b0, 32'h0, 32'h0); chk("ctrl wr", 32'h35, q);
        bus(1'b0, 32'h18, 32'h0); chk("unmapped", 32'h0, q);
        bus(1'b1, 32'h4, 32'h2); @(negedge clk);
        chk("io local", 0, io_rst);
    endtask : t_regs
    task automatic t_faults();
        @(posedge clk);
        want <= '{airflow_bad: 1'b1, ctrl_12v_lost: 1'b1, battery_fault: 1'b1,
                  tray_supply_fail: 4'h1, tray_fan_fail: 4'h4, clock_low_bad: 1'b1, default: '0};
        want_mod[N+1] <= 1'b1;
        settle();
        chk("blower", 1, leds.blower_fault_led);
        chk("leds", 32'h1be, leds);
        chk("halt", 1, halt);
        chk("fan", 1, leds.tray_fan_fault_led);
        chk("temp", 32'h2, temp_led);
        chk("quiet", 0, alarm);
        @(posedge clk); want <= '{ctrl_12v_lost: 1'b1, default: '0}; want_mod <= '0; settle();
        chk("resume", 0, halt);
        chk("fan off", 0, leds.tray_fan_fault_led);
    endtask : t_faults
    task automatic t_margin();
        @(posedge clk); want.low_rail_margin_up <= 1'b1; want.high_rail_margin_down <= 1'b1;
        settle();
        chk("margin", {CCFP_MARGIN_UP, CCFP_MARGIN_DOWN}, margin);
        chk("service", 1, leds.service_state_led);
        @(posedge clk); want.remote_select <= 1'b1; settle();
        chk("remote", {CCFP_MARGIN_UP, CCFP_MARGIN_UP}, margin);
        chk("bulk", 1, bulk);
        chk("ready", 1, leds.system_ok_led);
        bus(1'b1, 32'h4, 32'h2); @(negedge clk);
        chk("io rst", 1, io_rst);
        @(posedge clk); want <= '0; settle();
    endtask : t_margin
    task automatic t_alarm();
        @(posedge clk); want.alarm_enable_switch <= 1'b1; settle();
        @(posedge clk); want.ctrl_48v_lost <= 1'b1; settle();
        chk("48v", 1, leds.ctrl_48v_fault_led);
        chk("alarm", 1, alarm);
        @(posedge clk); want.ctrl_48v_lost <= 1'b0; settle();
        chk("hold", 1, alarm);
        @(posedge clk); want.alarm_ack_button <= 1'b1; settle();
        chk("ack", 0, alarm);
        @(posedge clk); want <= '0; settle();
    endtask : t_alarm
    task automatic t_latch();
        @(posedge clk); want_mod[0] <= 1'b1; settle();
        @(posedge clk); want_mod[0] <= 1'b0; settle();
        chk("latch", 1, pwr_led[0]);
        @(posedge clk); want_mod[2*N] <= 1'b1; settle();
        chk("cleared", 0, pwr_led[0]);
    endtask : t_latch
    task automatic t_cpu();
        int k;
        @(posedge clk); want.cpu_reset_button <= 1'b1;
        k = 0;
        while (cpu_irq !== 1'b1 && k < 60)
        begin
            @(negedge clk); k++;
        end
        k = 0;
        while (cpu_irq === 1'b1 && k < 99)
        begin
            @(negedge clk); k++;
        end
        chk("pulse", RST_PULSE_CYC, k);
        @(posedge clk); want.cpu_reset_button <= 1'b0;
    endtask : t_cpu
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        #500000;
        n_fail++;
        conclude();
    end
    initial
    begin
        rst = 1'b1; hsel = 1'b0; htrans = 2'h0; haddr = '0; hwrite = 1'b0; hwdata = '0;
        want = '0; want_mod = '0; n_fail = 0; cmp_count = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_regs(); t_faults(); t_margin(); t_alarm(); t_latch(); t_cpu();
        conclude();
    end
endmodule : test_ccfp_top
`default_nettype wire
